//--- sbc_mode_ctrl.sv
/*
  Operating-mode state machine of a system basis chip: reset stretch, normal request timeout,
  mode commands, wake-up handling with cyclic sense, and per-mode gating of switches, bus and inputs.
  Assumes all inputs are synchronous to i_clk_sys and that SPI decoding happens elsewhere: a mode
  command arrives as a one-cycle strobe with the two mode-select bits, and analog comparator
  flags arrive already filtered.
*/
// Behaviour
// - Power-up: reset low 1 ms, then normal request
// - Undervoltage, watchdog fail, sleep wake, timeout reset
// - Normal request follows reset and stop wake
// - Normal request: regulator on, reset high, rx-only
// - 150 ms window for timing and normal writes
// - Timeout in normal request returns to reset
// - Grounded watchdog pin skips normal request after reset
// - Mode-select bits choose the operating mode
// - Normal: full regulator, bus transmit and receive
// - Window watchdog only with external resistor
// - Normal mode raises supply and thermal interrupts
// - Sleep by command or long regulator low
// - Reset with regulator low, no supply low: sleep
// - Sleep: regulator off, only wake sources live
// - Cyclic sense: pulse high side, sample inputs
// - Cyclic sense wakes on sample change
// - Plain wake input level change wakes
// - Sleep wake goes to reset, reports source
// - Stop wake by a wake source asserts an interrupt; a chip-select rise does not
// - Muxed wake input loses digital and wake
// - Unmuxed wake input states readable
// - Switches by settings or follow pwm input
// - Stop only by command; wake to request
// - Reset held low 1 ms after source clears
// - Transmitter enabled only in normal mode
`timescale 1ns/1ps
`include "sbc_mode_regs.svh"

module sbc_mode_ctrl
  import sbc_mode_pkg::*;
#(
  parameter logic [31:0] RST_STRETCH_CYC   = `RST_STRETCH_CYC,
  parameter logic [31:0] NREQ_TIMEOUT_CYC  = `NREQ_TIMEOUT_CYC,
  parameter logic [31:0] VDD_LOW_SLEEP_CYC = `VDD_LOW_SLEEP_CYC,
  parameter logic [31:0] CS_PERIOD_CYC     = `CS_PERIOD_CYC,
  parameter logic [31:0] CS_ON_CYC         = `CS_ON_CYC,
  parameter logic [1:0]  MODE_SEL_SLEEP    = `MODE_SEL_SLEEP,
  parameter logic [1:0]  MODE_SEL_STOP     = `MODE_SEL_STOP
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_vdd_low,
  input  wire logic        i_supply_undervoltage_flag,
  input  wire logic        i_supply_overvoltage,
  input  wire logic        i_thermal_shutdown,
  input  wire logic        i_thermal_prewarn,
  input  wire logic        i_watchdog_fail,
  input  wire logic        i_watchdog_config_pin_gnd,
  input  wire logic        i_watchdog_config_pin_res,
  input  wire logic        i_ext_reset_n,
  input  wire logic        i_cs_rise,
  input  wire logic        i_mode_wr,
  input  wire logic [1:0]  i_mode_select_bits,
  input  wire logic        i_timing_wr,
  input  wire logic        i_cyclic_sense_en,
  input  wire logic        i_forced_wake,
  input  wire logic        i_bus_wake,
  input  wire switch_cfg_t i_sw_cfg,
  input  wire logic        i_pwm_input_pin,
  input  wire logic [1:0]  i_wake_mux_sel,
  input  wire logic        i_wake_input_a,
  input  wire logic        i_wake_input_b,
  input  wire logic        i_irq_ack,
  output logic             o_reset_n,
  output logic             o_reset_oe,
  output logic             o_reg_on,
  output logic             o_reg_full,
  output logic             o_lin_tx_en,
  output logic             o_lin_rx_en,
  output logic             o_low_side_switch_a,
  output logic             o_low_side_switch_b,
  output logic             o_high_side_switch,
  output logic             o_lp_osc_en,
  output logic             o_watchdog_en,
  output logic             o_irq_n,
  output logic [1:0]       o_wake_state,
  output wake_src_t        o_wake_src,
  output logic             o_battery_fail_flag,
  output op_mode_t         o_mode
);

  function automatic logic wake_change(input logic [1:0] a, input logic [1:0] b, input logic [1:0] en);
    wake_change = |((a ^ b) & en);
  endfunction

  op_mode_t    mode_q, mode_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] vlow_q, vlow_d;
  logic [31:0] cs_q, cs_d;
  logic        timing_ok_q, timing_ok_d;
  logic        irq_q, irq_d;
  logic        stop_irq_pend_q, stop_irq_pend_d;
  logic [1:0]  ref_q, ref_d;
  logic        cs_valid_q, cs_valid_d;
  wake_src_t   src_q, src_d;
  logic        bfail_q, bfail_d;
  logic        pwr_q, pwr_d;
  logic [1:0]  win;
  logic [1:0]  wen;
  logic        lowpwr;
  logic        cs_sample;
  logic        wake_inp;
  logic        wake_any;
  logic        reset_src;
  logic        sw_active;
  logic [2:0]  sw_lvl;

  // Inputs routed to the analog multiplexer are neither digital nor wake inputs.
  assign win       = {i_wake_input_b, i_wake_input_a};
  assign wen       = ~i_wake_mux_sel;
  assign lowpwr    = (mode_q == MODE_STOP) || (mode_q == MODE_SLEEP);
  assign cs_sample = i_cyclic_sense_en && (cs_q == CS_ON_CYC - 32'h1);
  assign wake_inp  = i_cyclic_sense_en ? (cs_sample && cs_valid_q && wake_change(win, ref_q, wen))
                                       : wake_change(win, ref_q, wen);
  assign wake_any  = lowpwr && (wake_inp || i_bus_wake || i_forced_wake);
  assign reset_src = i_vdd_low || i_watchdog_fail || !i_ext_reset_n;
  assign sw_active = (mode_q == MODE_NREQ) || (mode_q == MODE_NORMAL);

  always_comb begin
    mode_d          = mode_q;
    cnt_d           = cnt_q;
    timing_ok_d     = timing_ok_q;
    stop_irq_pend_d = 1'b0;
    src_d           = src_q;
    bfail_d         = bfail_q;
    pwr_d           = pwr_q;
    unique case (mode_q)
      MODE_RESET: begin
        // The stretch restarts while any source persists, so release is a full period after it clears.
        if (reset_src) begin
          cnt_d = 32'h0;
          // Just after a sleep wake the regulator is still rising, so only a long low counts then.
          if (i_vdd_low && !i_supply_undervoltage_flag && (!pwr_q || vlow_q >= VDD_LOW_SLEEP_CYC - 32'h1)) begin
            mode_d = MODE_SLEEP;
          end
        end else if (cnt_q >= RST_STRETCH_CYC - 32'h1) begin
          cnt_d       = 32'h0;
          timing_ok_d = 1'b0;
          pwr_d       = 1'b0;
          mode_d      = i_watchdog_config_pin_gnd ? MODE_NORMAL : MODE_NREQ;
        end else begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      MODE_NREQ: begin
        if (i_timing_wr) begin
          timing_ok_d = 1'b1;
        end
        if (reset_src) begin
          cnt_d  = 32'h0;
          mode_d = MODE_RESET;
        end else if (i_mode_wr && i_mode_select_bits == `MODE_SEL_NORMAL && (timing_ok_q || i_timing_wr)) begin
          cnt_d  = 32'h0;
          mode_d = MODE_NORMAL;
        end else if (cnt_q >= NREQ_TIMEOUT_CYC - 32'h1) begin
          cnt_d  = 32'h0;
          mode_d = MODE_RESET;
        end else begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      MODE_NORMAL: begin
        cnt_d = 32'h0;
        if (i_vdd_low && !i_supply_undervoltage_flag && vlow_q >= VDD_LOW_SLEEP_CYC - 32'h1) begin
          mode_d = MODE_SLEEP;
        end else if (reset_src) begin
          mode_d = MODE_RESET;
        end else if (i_mode_wr && i_mode_select_bits == MODE_SEL_SLEEP) begin
          mode_d = MODE_SLEEP;
        end else if (i_mode_wr && i_mode_select_bits == MODE_SEL_STOP) begin
          mode_d = MODE_STOP;
        end
        if (mode_d != MODE_NORMAL) begin
          src_d = '0;
        end
      end
      MODE_STOP: begin
        cnt_d = 32'h0;
        if (i_watchdog_fail || !i_ext_reset_n) begin
          mode_d = MODE_RESET;
        end else if (wake_any || i_cs_rise) begin
          mode_d          = MODE_NREQ;
          timing_ok_d     = 1'b0;
          stop_irq_pend_d = wake_any;
          src_d           = '{wake_a: wake_inp && ((win[0] ^ ref_q[0]) & wen[0]),
                              wake_b: wake_inp && ((win[1] ^ ref_q[1]) & wen[1]),
                              bus: i_bus_wake, forced: i_forced_wake};
        end
      end
      MODE_SLEEP: begin
        cnt_d = 32'h0;
        if (wake_any) begin
          mode_d  = MODE_RESET;
          pwr_d   = 1'b1;
          bfail_d = 1'b0;
          src_d   = '{wake_a: wake_inp && ((win[0] ^ ref_q[0]) & wen[0]),
                      wake_b: wake_inp && ((win[1] ^ ref_q[1]) & wen[1]),
                      bus: i_bus_wake, forced: i_forced_wake};
        end
      end
      default: begin
        mode_d = MODE_RESET;
        cnt_d  = 32'h0;
      end
    endcase
  end

  // Helper logic for the wake reference, cyclic-sense timebase and the long regulator-low timer.
  always_comb begin
    vlow_d     = ((mode_q == MODE_NORMAL || mode_q == MODE_RESET) && i_vdd_low && vlow_q != 32'hffffffff) ?
                 vlow_q + 32'h1 : 32'h0;
    cs_d       = 32'h0;
    cs_valid_d = cs_valid_q;
    ref_d      = ref_q;
    if (lowpwr && i_cyclic_sense_en) begin
      cs_d = (cs_q >= CS_PERIOD_CYC - 32'h1) ? 32'h0 : cs_q + 32'h1;
      if (cs_sample) begin
        ref_d      = win;
        cs_valid_d = 1'b1;
      end
    end else begin
      ref_d      = win;
      cs_valid_d = 1'b0;
    end
  end

  // Interrupt is held until acknowledged or reset goes low; a new event in the acknowledge cycle wins over the acknowledge, not over reset.
  always_comb begin
    irq_d = irq_q;
    if (i_irq_ack) begin
      irq_d = 1'b0;
    end
    if (mode_q == MODE_NORMAL && (i_supply_overvoltage || i_supply_undervoltage_flag ||
        i_thermal_shutdown || i_thermal_prewarn)) begin
      irq_d = 1'b1;
    end
    if (stop_irq_pend_q) begin
      irq_d = 1'b1;
    end
    if (!o_reset_n) begin
      irq_d = 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sw_lvl[i] = sw_active && (i_sw_cfg.sw_pwm[i] ? i_pwm_input_pin : i_sw_cfg.sw_on[i]);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q          <= MODE_RESET;
      cnt_q           <= 32'h0;
      vlow_q          <= 32'h0;
      cs_q            <= 32'h0;
      timing_ok_q     <= 1'b0;
      irq_q           <= 1'b0;
      stop_irq_pend_q <= 1'b0;
      ref_q           <= 2'h0;
      cs_valid_q      <= 1'b0;
      src_q           <= '0;
      bfail_q         <= 1'b1;
      pwr_q           <= 1'b0;
      o_reset_n       <= 1'b0;
      o_reset_oe      <= 1'b1;
      o_reg_on        <= 1'b1;
      o_reg_full      <= 1'b1;
      o_lin_tx_en     <= 1'b0;
      o_lin_rx_en     <= 1'b0;
      o_low_side_switch_a <= 1'b0;
      o_low_side_switch_b <= 1'b0;
      o_high_side_switch  <= 1'b0;
      o_lp_osc_en     <= 1'b0;
      o_watchdog_en   <= 1'b0;
      o_irq_n         <= 1'b1;
      o_wake_state    <= 2'h0;
      o_wake_src      <= '0;
      o_battery_fail_flag <= 1'b1;
      o_mode          <= MODE_RESET;
    end else begin
      mode_q          <= mode_d;
      cnt_q           <= cnt_d;
      vlow_q          <= vlow_d;
      cs_q            <= cs_d;
      timing_ok_q     <= timing_ok_d;
      irq_q           <= irq_d;
      stop_irq_pend_q <= stop_irq_pend_d;
      ref_q           <= ref_d;
      cs_valid_q      <= cs_valid_d;
      src_q           <= src_d;
      bfail_q         <= bfail_d;
      pwr_q           <= pwr_d;
      o_reset_n       <= (mode_d != MODE_RESET) && (mode_d != MODE_SLEEP);
      o_reset_oe      <= (mode_d == MODE_RESET) || (mode_d == MODE_SLEEP);
      o_reg_on        <= (mode_d != MODE_SLEEP);
      o_reg_full      <= (mode_d != MODE_SLEEP) && (mode_d != MODE_STOP);
      o_lin_tx_en     <= (mode_d == MODE_NORMAL);
      o_lin_rx_en     <= (mode_d != MODE_RESET);
      o_low_side_switch_a <= sw_lvl[`SW_LS_A_BIT];
      o_low_side_switch_b <= sw_lvl[`SW_LS_B_BIT];
      o_high_side_switch  <= sw_lvl[`SW_HS_BIT] ||
                             (lowpwr && i_cyclic_sense_en && cs_d < CS_ON_CYC);
      o_lp_osc_en     <= (mode_d == MODE_SLEEP || mode_d == MODE_STOP) && i_cyclic_sense_en;
      o_watchdog_en   <= (mode_d == MODE_NORMAL) && i_watchdog_config_pin_res;
      o_irq_n         <= !irq_d;
      o_wake_state    <= win & wen;
      o_wake_src      <= src_d;
      o_battery_fail_flag <= bfail_d;
      o_mode          <= mode_d;
    end
  end

  AST_TX_ONLY_NORMAL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_lin_tx_en |-> o_mode == MODE_NORMAL) else $error("transmitter on outside normal mode");
  AST_NREQ_RX_ONLY: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_mode == MODE_NREQ |-> o_reset_n && o_reg_on && !o_lin_tx_en) else $error("bad normal request outputs");
  AST_SLEEP_REG_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_mode == MODE_SLEEP |-> !o_reg_on) else $error("regulator on in sleep");
  AST_RESET_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_mode == MODE_RESET |-> !o_reset_n) else $error("reset line high in reset mode");
  AST_SLEEP_WAKE_RESET: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_q == MODE_SLEEP && wake_any |=> mode_q == MODE_RESET && !bfail_q) else $error("sleep wake not to reset");
  AST_STOP_WAKE_IRQ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_q == MODE_STOP && wake_any && i_ext_reset_n && !i_watchdog_fail |-> ##2 !o_irq_n)
    else $error("no interrupt after stop wake");
  AST_STOP_WAKE_NREQ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_q == MODE_STOP && i_cs_rise && i_ext_reset_n && !i_watchdog_fail |=> mode_q == MODE_NREQ)
    else $error("stop wake not to normal request");
  AST_NREQ_TIMEOUT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_q == MODE_NREQ && cnt_q >= NREQ_TIMEOUT_CYC - 32'h1 && !i_mode_wr |=> mode_q == MODE_RESET)
    else $error("timeout did not return to reset");
  AST_WD_GND_SKIP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(mode_q) == MODE_RESET && mode_q != MODE_RESET && mode_q != MODE_SLEEP && i_watchdog_config_pin_gnd
    |-> mode_q == MODE_NORMAL) else $error("grounded watchdog pin did not skip request");
  AST_MUX_NO_DIGITAL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(i_wake_mux_sel[0]) |-> !o_wake_state[0]) else $error("muxed input still readable");

endmodule

//--- sbc_mode_regs.svh
/*
  Constants for the operating-mode controller: mode-select encodings, field positions and timing figures.
  Assumes an includer that works at the 50 MHz system clock rate.
*/
`ifndef SBC_MODE_REGS_SVH
`define SBC_MODE_REGS_SVH

`define CLK_PERIOD_NS        20
`define RST_STRETCH_US       1000
`define NREQ_TIMEOUT_MS      150
`define VDD_LOW_SLEEP_MS     150
`define RST_STRETCH_CYC      ((`RST_STRETCH_US * 1000) / `CLK_PERIOD_NS)
`define NREQ_TIMEOUT_CYC     ((`NREQ_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define VDD_LOW_SLEEP_CYC    ((`VDD_LOW_SLEEP_MS * 1000000) / `CLK_PERIOD_NS)
`define CS_PERIOD_CYC        100000
`define CS_ON_CYC            50
`define MODE_SEL_NORMAL      2'h0
`define MODE_SEL_SLEEP       2'h1
`define MODE_SEL_STOP        2'h2
`define SW_LS_A_BIT          0
`define SW_LS_B_BIT          1
`define SW_HS_BIT            2

`endif

//--- sbc_mode_pkg.sv
/*
  Types shared by the operating-mode controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sbc_mode_pkg;

  typedef enum logic [2:0] {
    MODE_RESET  = 3'h0,
    MODE_NREQ   = 3'h1,
    MODE_NORMAL = 3'h2,
    MODE_STOP   = 3'h3,
    MODE_SLEEP  = 3'h4
  } op_mode_t;

  typedef struct packed {
    logic [2:0] sw_on;
    logic [2:0] sw_pwm;
  } switch_cfg_t;

  typedef struct packed {
    logic wake_a;
    logic wake_b;
    logic bus;
    logic forced;
  } wake_src_t;

endpackage

//--- host_mcu_model.sv
/*
  Behavioural host microcontroller: answers normal request, sends mode commands and acknowledges interrupts.
  Assumes the mode controller's clock, reset, mode and interrupt outputs; drives on the falling edge.
*/
`timescale 1ns/1ps
module host_mcu_model
  import sbc_mode_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire op_mode_t   i_mode,
  input  wire logic       i_irq_n,
  input  wire logic       i_auto,
  input  wire logic [7:0] i_lag,
  input  wire logic       i_cmd,
  input  wire logic [1:0] i_cmd_bits,
  output logic            o_mode_wr,
  output logic [1:0]      o_mode_select_bits,
  output logic            o_timing_wr,
  output logic            o_irq_ack
);
  logic [7:0] cnt;

  always @(negedge i_clk_sys) begin
    if (!i_rst_n) begin
      {o_mode_wr, o_timing_wr, o_irq_ack} <= 3'h0;
      o_mode_select_bits <= 2'h3;
      cnt <= 8'h00;
    end else begin
      o_mode_wr <= 1'b0;
      o_timing_wr <= 1'b0;
      o_irq_ack <= 1'b0;
      // Idle data keeps changing so that a design sampling it outside a write is caught.
      o_mode_select_bits <= ~o_mode_select_bits;
      cnt <= (i_mode == MODE_NREQ) ? cnt + 8'h01 : 8'h00;
      if (i_auto && i_mode == MODE_NREQ && cnt == i_lag) begin
        o_timing_wr <= 1'b1;
      end
      if (i_auto && i_mode == MODE_NREQ && cnt == i_lag + 8'h01) begin
        o_mode_wr <= 1'b1;
        o_mode_select_bits <= 2'h0;
      end
      if (i_cmd) begin
        o_mode_wr <= 1'b1;
        o_mode_select_bits <= i_cmd_bits;
      end
      // Acknowledge only in normal mode, so a stop wake interrupt stays visible during normal request.
      if (!i_irq_n && i_mode == MODE_NORMAL && !o_irq_ack) begin
        o_irq_ack <= 1'b1;
      end
    end
  end
endmodule

//--- sbc_operating_mode_controller_test.sv
/*
  Self-checking bench for the operating-mode controller driven by a host model.
  Assumes the package, header and design are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module sbc_operating_mode_controller_test
  import sbc_mode_pkg::*;
;
  localparam int RST = 20;
  localparam int NRQ = 200;
  localparam int VLO = 100;
  typedef struct packed {logic [1:0] bits; op_mode_t m; logic tx; logic on;} row_t;
  logic        clk, rst_n, vdd_low, wd_fail, wd_gnd, wd_res, cs_rise, cs_en, bus_wake, frc, pwm, wake_a, wake_b;
  logic        auto_ans, cmd, irq_ack, mode_wr, timing_wr, hs_seen, suv, prew, ext_n;
  logic        rst_o, oe, reg_on, reg_full, tx_en, rx_en, ls_a, ls_b, hs, lp_osc, wd_en, irq_n, bat_fail;
  logic [1:0]  cmd_bits, mux_sel, sel_bits, wake_st;
  logic [7:0]  lag;
  switch_cfg_t sw_cfg;
  wake_src_t   wsrc;
  op_mode_t    mode;
  int          checks, err_total;
  row_t        rows [3] = '{'{2'h1, MODE_SLEEP, 1'b0, 1'b0}, '{2'h2, MODE_STOP, 1'b0, 1'b1},
                            '{2'h0, MODE_NORMAL, 1'b1, 1'b1}};

  sbc_mode_ctrl #(.RST_STRETCH_CYC(RST), .NREQ_TIMEOUT_CYC(NRQ), .VDD_LOW_SLEEP_CYC(VLO), .CS_PERIOD_CYC(40),
    .CS_ON_CYC(4)) DUT (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_vdd_low(vdd_low), .i_supply_undervoltage_flag(suv),
    .i_supply_overvoltage(1'b0), .i_thermal_shutdown(1'b0), .i_thermal_prewarn(prew), .i_watchdog_fail(wd_fail),
    .i_watchdog_config_pin_gnd(wd_gnd), .i_watchdog_config_pin_res(wd_res), .i_ext_reset_n(ext_n),
    .i_cs_rise(cs_rise), .i_mode_wr(mode_wr), .i_mode_select_bits(sel_bits), .i_timing_wr(timing_wr),
    .i_cyclic_sense_en(cs_en), .i_forced_wake(frc), .i_bus_wake(bus_wake), .i_sw_cfg(sw_cfg),
    .i_pwm_input_pin(pwm), .i_wake_mux_sel(mux_sel), .i_wake_input_a(wake_a), .i_wake_input_b(wake_b),
    .i_irq_ack(irq_ack), .o_reset_n(rst_o), .o_reset_oe(oe), .o_reg_on(reg_on), .o_reg_full(reg_full),
    .o_lin_tx_en(tx_en), .o_lin_rx_en(rx_en), .o_low_side_switch_a(ls_a), .o_low_side_switch_b(ls_b),
    .o_high_side_switch(hs), .o_lp_osc_en(lp_osc), .o_watchdog_en(wd_en), .o_irq_n(irq_n),
    .o_wake_state(wake_st), .o_wake_src(wsrc), .o_battery_fail_flag(bat_fail), .o_mode(mode));

  host_mcu_model HOST (.i_clk_sys(clk), .i_rst_n(rst_n), .i_mode(mode), .i_irq_n(irq_n), .i_auto(auto_ans),
    .i_lag(lag), .i_cmd(cmd), .i_cmd_bits(cmd_bits), .o_mode_wr(mode_wr), .o_mode_select_bits(sel_bits),
    .o_timing_wr(timing_wr), .o_irq_ack(irq_ack));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait: a mode that never arrives is reported instead of hanging.
  task automatic wait_mode(input op_mode_t m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clk);
      n++;
    end
    `CHK(mode, m)
  endtask

  task automatic send(input logic [1:0] b);
    cmd_bits <= b;
    cmd <= 1'b1;
    @(negedge clk);
    cmd <= 1'b0;
  endtask

  initial begin
    #400000;
    err_total++;
    conclude();
  end

  initial begin
    {rst_n, vdd_low, wd_fail, wd_gnd, wd_res, cs_rise, cs_en, bus_wake, frc, pwm, wake_a, wake_b} = '0;
    {auto_ans, cmd, cmd_bits, mux_sel, sw_cfg, suv, prew} = '0;
    ext_n = 1'b1;
    lag = 8'h08;
    checks = 0;
    err_total = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK({mode, rst_o, oe}, {MODE_RESET, 2'b01})
    rst_n <= 1'b1;
    step(RST - 2);
    `CHK(rst_o, 1'b0)
    wait_mode(MODE_NREQ, 4);
    `CHK({rst_o, rx_en, tx_en, reg_on}, 4'hd)
    wait_mode(MODE_RESET, NRQ + 4);
    auto_ans <= 1'b1;
    wait_mode(MODE_NORMAL, RST + 20);
    `CHK({tx_en, rx_en, reg_full}, 3'h7)
    wd_res <= 1'b1;
    step(2);
    `CHK(wd_en, 1'b1)
    wd_res <= 1'b0;
    step(2);
    `CHK(wd_en, 1'b0)
    $display("end of reset and request test");
    for (int i = 0; i < 3; i++) begin
      send(rows[i].bits);
      wait_mode(rows[i].m, 4);
      `CHK({tx_en, reg_on}, {rows[i].tx, rows[i].on})
      wake_a <= ~wake_a;
      wait_mode(MODE_NORMAL, 60);
    end
    $display("end of mode table test");
    send(2'h2);
    wait_mode(MODE_STOP, 4);
    wake_b <= 1'b1;
    wait_mode(MODE_NREQ, 4);
    step(2);
    `CHK(irq_n, 1'b0)
    wait_mode(MODE_NORMAL, 30);
    step(3);
    `CHK(irq_n, 1'b1)
    send(2'h2);
    wait_mode(MODE_STOP, 4);
    cs_rise <= 1'b1;
    @(negedge clk);
    cs_rise <= 1'b0;
    wait_mode(MODE_NREQ, 4);
    step(2);
    `CHK(irq_n, 1'b1)
    wait_mode(MODE_NORMAL, 30);
    send(2'h2);
    wait_mode(MODE_STOP, 4);
    ext_n <= 1'b0;
    wait_mode(MODE_RESET, 4);
    step(5);
    ext_n <= 1'b1;
    step(RST - 2);
    `CHK({mode, irq_n}, {MODE_RESET, 1'b1})
    wait_mode(MODE_NREQ, 4);
    `CHK(irq_n, 1'b1)
    wait_mode(MODE_NORMAL, 30);
    $display("end of stop wake test");
    mux_sel <= 2'b01;
    step(2);
    `CHK(wake_st, {wake_b, 1'b0})
    send(2'h2);
    wait_mode(MODE_STOP, 4);
    wake_a <= ~wake_a;
    step(10);
    `CHK(mode, MODE_STOP)
    bus_wake <= 1'b1;
    wait_mode(MODE_NREQ, 6);
    bus_wake <= 1'b0;
    mux_sel <= 2'b00;
    wait_mode(MODE_NORMAL, 30);
    sw_cfg <= '{sw_on: 3'b001, sw_pwm: 3'b100};
    pwm <= 1'b1;
    step(3);
    `CHK({hs, ls_b, ls_a}, 3'b101)
    pwm <= 1'b0;
    step(3);
    `CHK({hs, ls_b, ls_a}, 3'b001)
    sw_cfg <= '0;
    $display("end of input and switch test");
    cs_en <= 1'b1;
    send(2'h1);
    wait_mode(MODE_SLEEP, 4);
    hs_seen = 1'b0;
    repeat (60) begin
      @(negedge clk);
      hs_seen = hs_seen | hs;
    end
    `CHK({hs_seen, lp_osc, mode}, {2'b11, MODE_SLEEP})
    wake_b <= ~wake_b;
    wait_mode(MODE_RESET, 90);
    `CHK({wsrc.wake_b, bat_fail}, 2'b10)
    cs_en <= 1'b0;
    wait_mode(MODE_NORMAL, RST + 30);
    prew <= 1'b1;
    step(2);
    `CHK(irq_n, 1'b0)
    prew <= 1'b0;
    step(4);
    `CHK(irq_n, 1'b1)
    suv <= 1'b1;
    step(2);
    `CHK(irq_n, 1'b0)
    vdd_low <= 1'b1;
    step(10);
    `CHK({mode, rst_o}, {MODE_RESET, 1'b0})
    suv <= 1'b0;
    wait_mode(MODE_SLEEP, 4);
    `CHK(reg_on, 1'b0)
    vdd_low <= 1'b0;
    frc <= 1'b1;
    wait_mode(MODE_RESET, 6);
    `CHK({wsrc.forced, bat_fail}, 2'b10)
    {frc, vdd_low} <= 2'b01;
    step(VLO - 10);
    `CHK(mode, MODE_RESET)
    wait_mode(MODE_SLEEP, 30);
    {frc, vdd_low} <= 2'b10;
    wait_mode(MODE_RESET, 6);
    frc <= 1'b0;
    wait_mode(MODE_NORMAL, RST + 30);
    $display("end of sleep test");
    wd_fail <= 1'b1;
    @(negedge clk);
    wd_fail <= 1'b0;
    wd_gnd <= 1'b1;
    wait_mode(MODE_RESET, 4);
    step(RST + 3);
    `CHK(mode, MODE_NORMAL)
    $display("end of watchdog pin test");
    conclude();
  end
endmodule
